// >>> hdl/asr_defs.svh
// constants for the asynchronous serial channel: end of transmit, receive path
// assumes inclusion by asr_pkg and asr_top only
//
// How it works
// (R1) software waits tx_shifting 0 before disabling
// (R2) last frame done: irq, both tx flags 0
// (R3) queued data: irq clears tx_buf_full, shifting stays
// (R4) software sets unit_power_on, then rx_allow
// (R5) falling edge starts; start confirmed mid-bit
// (R6) rx_allow 0: idle, buffer kept, no irqs
// (R7) receiver sampled by its rate_gen serial clock
// (R8) stop bit: rx_done_irq and holding buffer load
// (R9) overrun: flag set, frame dropped, irq
// (R10) parity/framing error: frame still stored, irq
// (R11) rx_allow cleared mid-frame aborts silently
// (R12) receiver checks only one stop bit
// (R13) fault_irq_merge picks fault or done irq
// (R14) reading rx_fault_reg clears all flags
// (R15) parity, framing and overrun causes
// (R16) even parity generation and check
// (R17) odd parity generation and check
// (R18) zero parity: send 0, never check
// (R19) no parity: no bit, no check
// (R20) two equal base_tick samples change input
// (R21) separate 8-bit tx and rx dividers
// (R22) software reads holding buffer every frame
// (R23) frames go least significant bit first
// (R24) base_tick only while unit_power_on
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

`define ASR_PAR_NONE 2'h0
`define ASR_PAR_ZERO 2'h1
`define ASR_PAR_ODD 2'h2
`define ASR_PAR_EVEN 2'h3
`define ASR_PRE_W 10
`define ASR_PRE_ZERO 10'h000
`define ASR_PRE_ALL 10'h3FF
`define ASR_PRE_ONE 10'h001
`define ASR_SEL_MAX 4'hA
`define ASR_DIV_W 8
`define ASR_DIV_ZERO 8'h00
`define ASR_DIV_ONE 8'h01
`define ASR_LAST_BIT8 3'h7
`define ASR_LAST_BIT7 3'h6
`define ASR_FIFO_FULL 2'h2
`define ASR_BYTE_ZERO 8'h00

`endif

// >>> hdl/asr_pkg.sv
// types shared by the serial channel
// assumes asr_defs.svh is on the include path
`include "asr_defs.svh"

package asr_pkg;
    // parity kinds of the mode register
    typedef enum logic [1:0] {
        ASR_PAR_NONE_E = `ASR_PAR_NONE,
        ASR_PAR_ZERO_E = `ASR_PAR_ZERO,
        ASR_PAR_ODD_E = `ASR_PAR_ODD,
        ASR_PAR_EVEN_E = `ASR_PAR_EVEN
    } asr_parity_e;

    // serial frame phases, shared by both directions
    typedef enum logic [2:0] {
        ASR_IDLE = 3'b000,
        ASR_START = 3'b001,
        ASR_DATA = 3'b010,
        ASR_PARITY = 3'b011,
        ASR_STOP = 3'b100
    } asr_state_e;

    // mode register fields
    typedef struct packed {
        asr_parity_e parity_mode; // parity kind
        logic char8;              // 1: 8 data bits, 0: 7
        logic stop2;              // transmit two stop bits
        logic fault_irq_merge;    // 1: errors on rx_done_irq
    } asr_mode_s;

    // transmit status
    typedef struct packed {
        logic tx_buf_full; // holding buffer occupied
        logic tx_shifting; // frame on the line
    } asr_tx_state_s;

    // receive error flags
    typedef struct packed {
        logic overrun_flag;
        logic parity_fault_flag;
        logic frame_fault_flag;
    } asr_fault_s;
endpackage

// >>> hdl/asr_top.sv
// serial channel: prescaler, split rate generator, transmitter, receiver, holding buffer
// assumes control bits are driven from the same clock and serial_in is asynchronous
`include "asr_defs.svh"
module asr_top
    import asr_pkg::*;
(
    input wire logic i_clock,                       // main clock, 20 MHz
    input wire logic i_resetn,                      // synchronous reset, low active
    input wire logic i_unit_power_on,               // channel power
    input wire logic i_tx_allow,                    // transmit enable
    input wire logic i_rx_allow,                    // receive enable
    input wire asr_mode_s i_mode_reg,               // frame format
    input wire logic [3:0] i_clk_sel,               // base clock divide select
    input wire logic [`ASR_DIV_W-1:0] i_tx_div,     // transmit divisor k
    input wire logic [`ASR_DIV_W-1:0] i_rx_div,     // receive divisor k
    input wire logic i_tx_valid,                    // write of tx_holding_buf
    input wire logic [7:0] i_tx_data,               // byte to send
    output logic o_tx_ready,                        // holding buffer may be written
    output asr_tx_state_s o_tx_state_reg,           // tx_buf_full, tx_shifting
    output logic o_tx_done_irq,                     // transmit done pulse
    output logic o_serial_out,                      // serial line out
    input wire logic i_serial_in,                   // serial line in
    output logic o_rx_valid,                        // rx_holding_buf has a byte
    output logic [7:0] o_rx_data,                   // oldest received byte
    input wire logic i_rx_ready,                    // read of rx_holding_buf
    output logic o_rx_done_irq,                     // receive done pulse
    output logic o_rx_fault_irq,                    // receive error pulse
    input wire logic i_fault_read,                  // read of rx_fault_reg
    output asr_fault_s o_rx_fault_reg               // error flags
);
    logic [`ASR_PRE_W-1:0] pre_cnt, next_pre_cnt, pre_mask; // prescaler
    logic base_tick;                                 // base clock enable
    logic sync1, sync2, sync3, pin, next_pin;        // pin synchroniser
    logic samp, next_samp, filt, next_filt, filt_prev; // noise filter
    asr_state_e tx_state, next_tx_state;             // transmit phase
    logic [`ASR_DIV_W-1:0] tx_cnt, next_tx_cnt;      // tx divider
    logic tx_ph, next_tx_ph, tx_half;                // tx half-bit phase
    logic [7:0] tx_buf, next_tx_buf, tx_sh, next_tx_sh; // holding and shift
    logic [2:0] tx_bits, next_tx_bits;               // data bit index
    logic tx_par, next_tx_par, tx_stop_n, next_tx_stop_n;
    logic next_serial_out, next_tx_done_irq, tx_wr, tx_on, tx_par_gen;
    asr_tx_state_s next_tx_state_reg;                // tx flags
    asr_state_e rx_state, next_rx_state;             // receive phase
    logic [`ASR_DIV_W-1:0] rx_cnt, next_rx_cnt;      // rx divider
    logic rx_ph, next_rx_ph, rx_half, rx_on;         // rx half-bit phase
    logic [7:0] rx_sh, next_rx_sh;                   // receive shift register
    logic [2:0] rx_bits, next_rx_bits;
    logic rx_acc, next_rx_acc;                       // running parity
    logic rx_pe, next_rx_pe, rx_push;                // parity error of frame
    logic next_rx_done_irq, next_rx_fault_irq;
    asr_fault_s flag_set, next_fault;                // fault flag updates
    logic [7:0] mem [0:1], next_mem [0:1];           // rx_holding_buf entries
    logic wp, next_wp, rp, next_rp, pop;             // buffer pointers
    logic [1:0] fcnt, next_fcnt;                     // buffer fill
    logic [2:0] last_bit;                            // final data bit index
    assign last_bit = i_mode_reg.char8 ? `ASR_LAST_BIT8 : `ASR_LAST_BIT7;
    // prescaler: base_tick every 2^sel clocks, sel above 10 acting as 10, held off with the unit
    always_comb begin
        if (i_clk_sel > `ASR_SEL_MAX) begin
            pre_mask = `ASR_PRE_ALL;
        end else begin
            pre_mask = (`ASR_PRE_ONE << i_clk_sel) - `ASR_PRE_ONE;
        end
        next_pre_cnt = i_unit_power_on ? pre_cnt + `ASR_PRE_ONE : `ASR_PRE_ZERO;
        base_tick = i_unit_power_on && ((pre_cnt & pre_mask) == `ASR_PRE_ZERO); // [R24]
    end
    always_ff @(posedge i_clock) begin
        if (!i_resetn) pre_cnt <= `ASR_PRE_ZERO;
        else pre_cnt <= next_pre_cnt;
    end
    // pin synchroniser and two-sample noise filter on base_tick
    always_comb begin
        next_pin = (sync2 == sync3) ? sync3 : pin;
        next_samp = base_tick ? pin : samp;
        next_filt = (base_tick && pin == samp) ? pin : filt; // [R20]
    end
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            {sync1, sync2, sync3, pin, samp, filt, filt_prev} <= 7'h7F; // idle high, no false edge
        end else begin
            {sync1, sync2, sync3} <= {i_serial_in, sync1, sync2}; // three-stage synchroniser
            {pin, samp, filt, filt_prev} <= {next_pin, next_samp, next_filt, filt};
        end
    end
    // transmitter: own divider, frame sequencer, holding buffer
    assign tx_on = i_unit_power_on && i_tx_allow;
    assign o_tx_ready = tx_on && !o_tx_state_reg.tx_buf_full;
    assign tx_wr = i_tx_valid && o_tx_ready;
    assign tx_half = base_tick && (tx_cnt == i_tx_div - `ASR_DIV_ONE); // [R21]
    always_comb begin
        next_tx_state = tx_state;
        next_tx_cnt = tx_cnt;
        next_tx_ph = tx_ph;
        next_tx_buf = tx_wr ? i_tx_data : tx_buf;
        next_tx_sh = tx_sh;
        next_tx_bits = tx_bits;
        next_tx_par = tx_par;
        next_tx_stop_n = tx_stop_n;
        next_tx_state_reg = o_tx_state_reg;
        next_tx_done_irq = 1'b0;
        if (tx_wr) next_tx_state_reg.tx_buf_full = 1'b1;
        case (i_mode_reg.parity_mode) // parity bit from the byte about to load
            ASR_PAR_EVEN_E: tx_par_gen = ^(tx_buf & {i_mode_reg.char8, 7'h7F}); // [R16]
            ASR_PAR_ODD_E: tx_par_gen = ~^(tx_buf & {i_mode_reg.char8, 7'h7F}); // [R17]
            default: tx_par_gen = 1'b0; // [R18]
        endcase
        if (tx_state != ASR_IDLE && base_tick) begin
            next_tx_cnt = tx_half ? `ASR_DIV_ZERO : tx_cnt + `ASR_DIV_ONE;
        end
        if (tx_state == ASR_IDLE) begin
            if (o_tx_state_reg.tx_buf_full) begin
                next_tx_sh = tx_buf;
                next_tx_par = tx_par_gen;
                next_tx_state_reg = '{tx_buf_full: 1'b0, tx_shifting: 1'b1};
                next_tx_state = ASR_START;
                next_tx_cnt = `ASR_DIV_ZERO;
                next_tx_ph = 1'b0;
            end
        end else if (tx_half) begin
            next_tx_ph = !tx_ph;
            if (tx_ph) begin
                case (tx_state)
                    ASR_START: begin
                        next_tx_state = ASR_DATA;
                        next_tx_bits = 3'h0;
                    end
                    ASR_DATA: begin
                        next_tx_sh = {1'b0, tx_sh[7:1]}; // [R23]
                        next_tx_bits = tx_bits + 3'h1;
                        if (tx_bits == last_bit) begin
                            next_tx_state = (i_mode_reg.parity_mode == ASR_PAR_NONE_E) ? ASR_STOP : ASR_PARITY; // [R19]
                            next_tx_stop_n = 1'b0;
                        end
                    end
                    ASR_PARITY: next_tx_state = ASR_STOP;
                    default: begin
                        if (i_mode_reg.stop2 && !tx_stop_n) begin
                            next_tx_stop_n = 1'b1;
                        end else begin
                            next_tx_done_irq = 1'b1;
                            if (o_tx_state_reg.tx_buf_full) begin
                                // queued byte moves on: buffer frees, still shifting [R3]
                                next_tx_sh = tx_buf;
                                next_tx_par = tx_par_gen;
                                next_tx_state_reg.tx_buf_full = 1'b0;
                                next_tx_state = ASR_START;
                            end else begin
                                // last frame: both flags drop with the irq [R2]
                                next_tx_state_reg.tx_shifting = 1'b0;
                                next_tx_state = ASR_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
        case (next_tx_state)
            ASR_START: next_serial_out = 1'b0;
            ASR_DATA: next_serial_out = next_tx_sh[0];
            ASR_PARITY: next_serial_out = next_tx_par;
            default: next_serial_out = 1'b1;
        endcase
    end
    always_ff @(posedge i_clock) begin
        if (!i_resetn || !tx_on) begin
            // disabling reinitialises the transmitter [R1]
            tx_state <= ASR_IDLE;
            tx_cnt <= `ASR_DIV_ZERO;
            tx_ph <= 1'b0;
            tx_buf <= `ASR_BYTE_ZERO;
            tx_sh <= `ASR_BYTE_ZERO;
            tx_bits <= 3'h0;
            tx_par <= 1'b0;
            tx_stop_n <= 1'b0;
            o_tx_state_reg <= '0;
            o_tx_done_irq <= 1'b0;
            o_serial_out <= 1'b1;
        end else begin
            tx_state <= next_tx_state;
            tx_cnt <= next_tx_cnt;
            tx_ph <= next_tx_ph;
            tx_buf <= next_tx_buf;
            tx_sh <= next_tx_sh;
            tx_bits <= next_tx_bits;
            tx_par <= next_tx_par;
            tx_stop_n <= next_tx_stop_n;
            o_tx_state_reg <= next_tx_state_reg;
            o_tx_done_irq <= next_tx_done_irq;
            o_serial_out <= next_serial_out;
        end
    end
    // receiver: own divider clocks the sampling of the filtered input [R7]
    assign rx_on = i_unit_power_on && i_rx_allow;
    assign rx_half = base_tick && (rx_cnt == i_rx_div - `ASR_DIV_ONE); // [R21]
    assign pop = o_rx_valid && i_rx_ready;
    always_comb begin
        next_rx_state = rx_state;
        next_rx_cnt = rx_cnt;
        next_rx_ph = rx_ph;
        next_rx_sh = rx_sh;
        next_rx_bits = rx_bits;
        next_rx_acc = rx_acc;
        next_rx_pe = rx_pe;
        next_rx_done_irq = 1'b0;
        next_rx_fault_irq = 1'b0;
        rx_push = 1'b0;
        flag_set = '0;
        if (rx_state != ASR_IDLE && base_tick) begin
            next_rx_cnt = rx_half ? `ASR_DIV_ZERO : rx_cnt + `ASR_DIV_ONE;
        end
        if (rx_state == ASR_IDLE) begin
            if (filt_prev && !filt) begin
                // falling edge: count half a bit to the start sample [R5]
                next_rx_state = ASR_START;
                next_rx_cnt = `ASR_DIV_ZERO;
                next_rx_ph = 1'b0;
            end
        end else if (rx_half) begin
            next_rx_ph = !rx_ph;
            case (rx_state)
                ASR_START: begin
                    next_rx_ph = 1'b0;
                    next_rx_bits = 3'h0;
                    next_rx_acc = 1'b0;
                    next_rx_pe = 1'b0;
                    next_rx_state = filt ? ASR_IDLE : ASR_DATA; // [R5]
                end
                ASR_DATA: if (rx_ph) begin
                    next_rx_sh = {filt, rx_sh[7:1]}; // [R23]
                    next_rx_acc = rx_acc ^ filt;
                    next_rx_bits = rx_bits + 3'h1;
                    if (rx_bits == last_bit) begin
                        next_rx_state = (i_mode_reg.parity_mode == ASR_PAR_NONE_E) ? ASR_STOP : ASR_PARITY; // [R19]
                    end
                end
                ASR_PARITY: if (rx_ph) begin
                    case (i_mode_reg.parity_mode)
                        ASR_PAR_EVEN_E: next_rx_pe = rx_acc ^ filt; // [R16]
                        ASR_PAR_ODD_E: next_rx_pe = !(rx_acc ^ filt); // [R17]
                        default: next_rx_pe = 1'b0; // [R18]
                    endcase
                    next_rx_state = ASR_STOP;
                end
                default: if (rx_ph && rx_on) begin // disabled in the stop cycle: frame dropped [R11]
                    // single stop bit; a second one is just idle line [R12]
                    flag_set.frame_fault_flag = !filt; // [R15]
                    flag_set.parity_fault_flag = rx_pe; // [R10]
                    flag_set.overrun_flag = (fcnt == `ASR_FIFO_FULL) && !pop; // [R9] [R22]
                    rx_push = !flag_set.overrun_flag; // [R8] [R10]
                    if (flag_set != '0 && !i_mode_reg.fault_irq_merge) begin
                        next_rx_fault_irq = 1'b1; // [R13]
                    end else begin
                        next_rx_done_irq = 1'b1; // [R8] [R13]
                    end
                    next_rx_state = ASR_IDLE;
                end
            endcase
        end
        next_fault = (i_fault_read ? asr_fault_s'('0) : o_rx_fault_reg) | flag_set; // read clears, set wins [R14]
    end
    always_ff @(posedge i_clock) begin
        if (!i_resetn || !rx_on) begin
            // disabled: idle, frame dropped, no irq [R6] [R11]
            rx_state <= ASR_IDLE;
            rx_cnt <= `ASR_DIV_ZERO;
            rx_ph <= 1'b0;
            rx_sh <= `ASR_BYTE_ZERO;
            rx_bits <= 3'h0;
            rx_acc <= 1'b0;
            rx_pe <= 1'b0;
            o_rx_done_irq <= 1'b0;
            o_rx_fault_irq <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            rx_cnt <= next_rx_cnt;
            rx_ph <= next_rx_ph;
            rx_sh <= next_rx_sh;
            rx_bits <= next_rx_bits;
            rx_acc <= next_rx_acc;
            rx_pe <= next_rx_pe;
            o_rx_done_irq <= next_rx_done_irq;
            o_rx_fault_irq <= next_rx_fault_irq;
        end
    end
    // rx_holding_buf: two entries, a third frame while the reader stalls is dropped as overrun
    always_comb begin
        next_mem = mem;
        next_wp = wp;
        next_rp = rp;
        if (rx_push) begin
            next_mem[wp] = i_mode_reg.char8 ? next_rx_sh : {1'b0, next_rx_sh[7:1]};
            next_wp = !wp;
        end
        if (pop) next_rp = !rp;
        next_fcnt = fcnt + {1'b0, rx_push} - {1'b0, pop};
    end
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            mem[0] <= `ASR_BYTE_ZERO;
            mem[1] <= `ASR_BYTE_ZERO;
            wp <= 1'b0;
            rp <= 1'b0;
            fcnt <= 2'h0;
            o_rx_fault_reg <= '0;
        end else begin
            mem <= next_mem;
            wp <= next_wp;
            rp <= next_rp;
            fcnt <= next_fcnt;
            o_rx_fault_reg <= next_fault;
        end
    end
    assign o_rx_valid = (fcnt != 2'h0);
    assign o_rx_data = mem[rp];
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    a_tick_off: assert property (!i_unit_power_on |-> !base_tick) else $error("base tick while unit off"); // [R24]
    a_rx_off_quiet: assert property (!i_rx_allow |=> !o_rx_done_irq && !o_rx_fault_irq) // [R6]
        else $error("receive irq while disabled");
    a_hold_kept: assert property (!i_rx_allow && !pop |=> $stable(fcnt)) // [R11]
        else $error("holding buffer changed while disabled");
    a_split_fault: assert property (o_rx_fault_irq |-> !$past(i_mode_reg.fault_irq_merge)) // [R13]
        else $error("fault irq while merged");
    a_fault_flags: assert property (o_rx_fault_irq |-> o_rx_fault_reg != '0) // [R15]
        else $error("fault irq without a flag");
    a_read_clears: assert property (i_fault_read && flag_set == '0 |=> o_rx_fault_reg == '0) // [R14]
        else $error("fault read did not clear");
    a_overrun_drop: assert property (rx_push == 1'b0 && flag_set.overrun_flag |=> fcnt == `ASR_FIFO_FULL) // [R9]
        else $error("overrun frame was stored");
    a_last_done: assert property (o_tx_done_irq && !o_tx_state_reg.tx_shifting && !$past(tx_wr)
        |-> !o_tx_state_reg.tx_buf_full) else $error("tx flags not both clear"); // [R2]
    a_queued_done: assert property (o_tx_done_irq && o_tx_state_reg.tx_shifting
        |-> tx_state == ASR_START) else $error("queued byte not started"); // [R3]
    a_filter_glitch: assert property ($changed(filt) |-> $past(samp) == filt) // [R20]
        else $error("filter passed a single sample");
    a_start_check: assert property (rx_state == ASR_START && rx_half && filt && rx_on |=> rx_state == ASR_IDLE) // [R5]
        else $error("false start accepted");
endmodule

// >>> verification/asr_far_end.sv
// remote serial device: sends frames into the channel and decodes what it sends out
// assumes bit time is a whole number of channel clocks and 8 data bits
module asr_far_end #(
    parameter int BIT = 16          // clocks per bit, equal to 2k at base_tick every clock
) (
    input wire logic i_clock,       // channel clock
    input wire logic i_line_in,     // channel serial output
    output logic o_line_out,        // channel serial input
    output logic o_got,             // one-cycle pulse, byte decoded
    output logic [7:0] o_byte,      // decoded byte
    output logic o_par              // decoded parity bit
);
    timeunit 1ns;
    timeprecision 1ns;
    // one bit on the wire, changed after the falling edge
    task automatic bit_out(input logic v);
        o_line_out = v;
        repeat (BIT) @(negedge i_clock);
    endtask
    // whole frame, optionally with a wrong parity bit or a low stop bit
    task automatic send(input logic [7:0] d, input logic [1:0] pm, input logic bad_par, input logic bad_stop);
        logic par;
        par = ^d ^ (pm == 2'h2) ^ bad_par; // even and odd generation
        if (pm == 2'h1) par = bad_par; // zero parity sends 0 unless broken
        bit_out(1'b0); // start bit
        for (int i = 0; i < 8; i++) bit_out(d[i]); // least significant first
        if (pm != 2'h0) bit_out(par); // no bit at all without parity
        bit_out(~bad_stop); // single stop bit
        bit_out(1'b1); // line released: idle high for one bit time
    endtask
    // short low glitch, then idle long enough for the receiver to give up
    task automatic pulse(input int n);
        o_line_out = 1'b0;
        repeat (n) @(negedge i_clock);
        o_line_out = 1'b1;
        repeat (2 * BIT) @(negedge i_clock);
    endtask
    initial begin
        o_line_out = 1'b1;
        o_got = 1'b0;
        o_byte = 8'h00;
        o_par = 1'b0;
    end
    // decoder: mid-bit sampling after a falling edge, even parity frames assumed
    initial forever begin
        @(negedge i_line_in);
        repeat (BIT / 2) @(negedge i_clock);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(negedge i_clock);
            o_byte[i] = i_line_in; // least significant first
        end
        repeat (BIT) @(negedge i_clock);
        o_par = i_line_in;
        repeat (BIT) @(negedge i_clock);
        o_got = 1'b1;
        @(negedge i_clock);
        o_got = 1'b0;
    end
endmodule

// >>> verification/asr_top_tb_top.sv
// bench for the serial channel: receive modes, faults, overrun, abort, continuous send
// assumes base_tick every clock and both divisors 8, so one bit is 16 clocks
module asr_top_tb_top import asr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rstn = 1'b0, pwr = 1'b0, txa = 1'b0, rxa = 1'b0, txv = 1'b0, rxr = 1'b1, frd = 1'b0;
    logic [7:0] txd = 8'h00, rxd, fb;
    logic rxv, txr, tirq, dirq, firq, sout, sin, fgot, fpar;
    asr_mode_s mode = '{ASR_PAR_NONE_E, 1'b1, 1'b0, 1'b0};
    asr_tx_state_s tst;
    asr_fault_s flt;
    int err_total = 0, compares = 0, cyc = 0, dn = 0, fc = 0, tc = 0;
    logic [15:0] rnd = 16'h7687; // seed
    logic [7:0] exp_rx[$], exp_tx[$], d;
    always #25 clk = ~clk; // 20 MHz
    asr_top u_asr_top (.i_clock(clk), .i_resetn(rstn), .i_unit_power_on(pwr), .i_tx_allow(txa),
        .i_rx_allow(rxa), .i_mode_reg(mode), .i_clk_sel(4'h0), .i_tx_div(8'h08), .i_rx_div(8'h08),
        .i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(txr), .o_tx_state_reg(tst), .o_tx_done_irq(tirq),
        .o_serial_out(sout), .i_serial_in(sin), .o_rx_valid(rxv), .o_rx_data(rxd), .i_rx_ready(rxr),
        .o_rx_done_irq(dirq), .o_rx_fault_irq(firq), .i_fault_read(frd), .o_rx_fault_reg(flt));
    asr_far_end u_asr_far_end (.i_clock(clk), .i_line_in(sout), .o_line_out(sin), .o_got(fgot),
        .o_byte(fb), .o_par(fpar));
    // comparison of one seen value against its expectation
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic results();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // next pseudo-random byte from a 16-bit shift register
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // pulse counters and hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            results();
        end
        dn += dirq;
        fc += firq;
        tc += tirq;
        if (tirq) check("irq tx state", 8'(tst), (tc == 1) ? 8'h01 : 8'h00);
    end
    // receive watcher: oldest expected byte against each pop
    always @(posedge clk) if (rstn && rxv === 1'b1 && rxr) begin
        d = exp_rx.pop_front();
        check("rx byte", rxd, d);
    end
    // line watcher: bytes decoded by the remote side
    always @(posedge clk) if (fgot) begin
        d = exp_tx.pop_front();
        check("tx byte", fb, d);
        check("tx parity", {7'h00, ^{fb, fpar}}, 8'h00);
    end
    task automatic rx_frame(input logic [1:0] pm, input logic bp, input logic bs, input logic keep);
        rnd = lfsr(rnd);
        if (keep) exp_rx.push_back(rnd[7:0]);
        mode.parity_mode = asr_parity_e'(pm);
        u_asr_far_end.send(rnd[7:0], pm, bp, bs);
        repeat (4) @(negedge clk);
    endtask
    task automatic read_faults(input logic [2:0] e, input string name);
        check(name, {5'h00, flt}, {5'h00, e});
        frd = 1'b1;
        @(negedge clk);
        frd = 1'b0;
        @(negedge clk);
        check("cleared flags", {5'h00, flt}, 8'h00);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        pwr = 1'b1;
        @(negedge clk);
        rxa = 1'b1; // power first, then receive enable
        txa = 1'b1;
        // every parity kind, zero parity with a wrong bit too
        for (int pm = 0; pm < 4; pm++) rx_frame(2'(pm), pm == 1, 1'b0, 1'b1);
        read_faults(3'b000, "flags clean");
        check("done count", 8'(dn), 8'h04);
        $display("test parity kinds done");
        rx_frame(2'h3, 1'b1, 1'b0, 1'b1); // even parity, wrong bit
        check("fault irq", 8'(fc), 8'h01);
        read_faults(3'b010, "parity flag");
        rx_frame(2'h2, 1'b1, 1'b0, 1'b1); // odd parity, wrong bit
        read_faults(3'b010, "odd flag");
        mode.fault_irq_merge = 1'b1;
        rx_frame(2'h3, 1'b0, 1'b1, 1'b1); // missing stop bit
        check("merged irq", 8'(dn), 8'h05);
        read_faults(3'b001, "frame flag");
        $display("test faults done");
        rxr = 1'b0;
        for (int i = 0; i < 3; i++) rx_frame(2'h0, 1'b0, 1'b0, i < 2);
        check("overrun done irqs", 8'(dn), 8'h08);
        read_faults(3'b100, "overrun flag");
        rxr = 1'b1; // reader drains the holding buffer
        repeat (4) @(negedge clk);
        $display("test overrun done");
        fork
            rx_frame(2'h0, 1'b0, 1'b0, 1'b0);
            begin
                repeat (60) @(negedge clk);
                rxa = 1'b0;
            end
        join
        rxa = 1'b1;
        check("abort irqs", 8'(dn + fc), 8'h0A);
        check("abort valid", {7'h00, rxv}, 8'h00);
        check("abort flags", {5'h00, flt}, 8'h00);
        $display("test abort done");
        u_asr_far_end.pulse(1); // one clock wide: filtered out
        u_asr_far_end.pulse(4); // passes the filter, start sample finds line high
        check("glitch irqs", 8'(dn + fc), 8'h0A);
        check("glitch valid", {7'h00, rxv}, 8'h00);
        check("glitch flags", {5'h00, flt}, 8'h00);
        $display("test glitch done");
        mode.parity_mode = ASR_PAR_EVEN_E;
        for (int i = 0; i < 2; i++) begin
            for (int w = 0; w < 400 && txr !== 1'b1; w++) @(negedge clk);
            rnd = lfsr(rnd);
            exp_tx.push_back(rnd[7:0]);
            txd = rnd[7:0];
            txv = 1'b1;
            @(negedge clk);
            txv = 1'b0;
        end
        repeat (2) @(negedge clk);
        check("queued state", 8'(tst), 8'h03);
        for (int w = 0; w < 600 && tc < 2; w++) @(negedge clk);
        @(negedge clk);
        check("end state", 8'(tst), 8'h00);
        check("tx irqs", 8'(tc), 8'h02);
        txa = 1'b0; // disable only after tx_shifting reads 0
        repeat (40) @(negedge clk);
        check("tx all seen", 8'(exp_tx.size()), 8'h00);
        check("line idle", {7'h00, sout}, 8'h01);
        check("ready off", {7'h00, txr}, 8'h00);
        $display("test continuous send done");
        results();
    end
endmodule
